// [logic/cbo_cbit_overhead.sv]
// C-bit overhead: alarm-channel code rx/tx, path parity, FEBE, PERFORMANCE_MONITOR counters
//
// Functional notes
// RL1: Receiver ignores all-ones code, accepts other 63
// RL2: Receive word: eight ones, zero, code, zero
// RL3: Validate after ten repeats, 8/10 or 4/5
// RL4: Interrupt on code valid and on disappearance
// RL5: Invalid code reported as all ones
// RL6: Transmit repeats code; all ones disables sending
// RL7: Transmit word: eight ones, zero, code, zero
// RL8: Loopback: command ten times, then line code; no loopback logic here
// RL9: Send while condition lasts, ten minimum; here no minimum, sending stops after the current word once all ones is written
// RL10: Control messages outrank alarms; listed priority; here one host-written code register, no priority logic
// RL11: Unused application C-bits sent as ones
// RL12: CP-bits copy the frame's P-bit value
// RL13: Frame n parity versus CP majority n+1
// RL14: FEBE 111 when clean, else error pattern
// RL15: Six separate host-readable clearable counters
// RL16: Counters saturate, never wrap
// RL17: Access moves count to holding, restarts counter
// RL18: Each transfer raises maskable interrupt
// RL19: Transfer over unread holding sets overrun
// RL20: Data-link C-bits ones while link unused
// RL21: Far end idles link with flags
// RL22: Zero stuffing keeps flags out of frames
// RL23: Ratio select bit lives at 0x32
// RL24: Codeword serialised right-most bit first
// RL25: Idle alarm channel carries all ones
// RL26: Holding read shows count at last transfer
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module cbo_cbit_overhead (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  // Host register port
  input  wire logic [cbo_pkg::ADDR_W-1:0]  hostAddr,
  input  wire logic [cbo_pkg::DATA_W-1:0]  hostWrData,
  input  wire logic                        hostWrStb,
  input  wire logic                        hostRdStb,
  output logic      [cbo_pkg::DATA_W-1:0]  hostRdData_q,
  // Interrupt lines
  output logic                             feacIrq_q,
  output logic                             pmonIrq_q,
  // Receive alarm channel from framer
  input  wire logic                        rxFeacBit,
  input  wire logic                        rxFeacValid,
  // Transmit alarm channel to framer
  input  wire logic                        txFeacReq,
  output logic                             txFeacBit_q,
  // Transmit overhead bits
  input  wire logic                        txFrameStart,
  input  wire logic                        txPbit,
  output logic      [2:0]                  txCpBits_q,
  output logic      [2:0]                  txFebeBits_q,
  output logic      [2:0]                  txAppBits_q,
  output logic      [2:0]                  txDlBits_q,
  // Receive parity path
  input  wire logic                        rxInfoBit,
  input  wire logic                        rxInfoValid,
  input  wire logic                        rxFrameEnd,
  input  wire logic [2:0]                  rxCpBits,
  input  wire logic                        rxCpValid,
  input  wire logic [2:0]                  rxFebeBits,
  input  wire logic                        rxFebeValid,
  // Error events from line and framer
  input  wire logic                        exzsEvt,
  input  wire logic                        ferrEvt,
  input  wire logic                        lcvEvt,
  input  wire logic                        perrEvt
);
  import cbo_pkg::*;

  // Ones count of a windowed history
  function automatic logic [3:0] onesIn(input logic [9:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 10; k++) begin
      n = n + {3'h0, v[k]};
    end
    return n;
  endfunction

  // Two-of-three vote
  function automatic logic majority3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // Host decode
  logic rdRx;                               // Read of reported code
  logic rdStat;                             // Read of alarm status
  logic rdXfer;                             // Read of transfer status
  logic rdOvr;                              // Read of overrun status
  assign rdRx   = hostRdStb && hostAddr == ADR_RX_CODE;
  assign rdStat = hostRdStb && hostAddr == ADR_FEAC_STAT;
  assign rdXfer = hostRdStb && hostAddr == ADR_PM_XFER;
  assign rdOvr  = hostRdStb && hostAddr == ADR_PM_OVR;

  // Configuration registers
  logic [5:0] txCode_q;                     // Code to transmit
  logic       ratioSel_q;                   // 1 selects 4 of 5
  logic       feacIen_q;                    // Alarm-channel irq enable
  logic [5:0] pmEn_q;                       // Transfer irq enables

  // Host writes to configuration
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txCode_q   <= TX_CODE_RST;
      ratioSel_q <= 1'b0;
      feacIen_q  <= 1'b0;
      pmEn_q     <= 6'h00;
    end else if (hostWrStb) begin
      if (hostAddr == ADR_TX_CODE) begin
        txCode_q <= hostWrData[5:0];
      end
      if (hostAddr == ADR_FEAC_CFG) begin
        ratioSel_q <= hostWrData[CFG_RATIO_BIT];  // RL23
        feacIen_q  <= hostWrData[CFG_IEN_BIT];
      end
      if (hostAddr == ADR_PM_EN) begin
        pmEn_q <= hostWrData[5:0];
      end
    end
  end

  // Receive word framing
  logic [15:0] rxSr_q;                      // Last sixteen channel bits
  logic [3:0]  rxBit_q;                     // Bits since last word
  logic [15:0] rxShift;                     // Shift with the new bit
  logic        wordHit;                     // Framed word present
  logic        wordDone;                    // Word boundary reached
  logic [5:0]  wordCode;                    // Code of finished word
  // First bit on the wire ends up in bit 0
  assign rxShift  = {rxFeacBit, rxSr_q[15:1]};
  assign wordHit  = rxShift[7:0] == WORD_HDR && !rxShift[8] && !rxShift[15];  // RL2
  assign wordDone = rxFeacValid && (wordHit || rxBit_q == WORD_LAST);
  // Unframed words count as no code
  assign wordCode = wordHit ? rxShift[14:9] : CODE_NONE;

  // Shift register and word alignment
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxSr_q  <= 16'hFFFF;
      rxBit_q <= 4'h0;
    end else if (rxFeacValid) begin
      rxSr_q  <= rxShift;
      // Realign on every framed word
      rxBit_q <= wordDone ? 4'h0 : rxBit_q + 4'h1;
    end
  end

  // Candidate tracking
  logic [5:0] cand_q;                       // Code being validated
  logic [9:0] hist_q;                       // Agreement history, newest bit 0
  logic [3:0] seen_q;                       // Words since candidate chosen
  // Single stray words are tolerated; two misses in a row switch
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cand_q <= CODE_NONE;
      hist_q <= 10'h000;
      seen_q <= 4'h0;
    end else if (wordDone) begin
      if (wordCode != cand_q && !hist_q[0]) begin
        cand_q <= wordCode;
        hist_q <= 10'h001;
        seen_q <= 4'h1;
      end else begin
        hist_q <= {hist_q[8:0], wordCode == cand_q};
        seen_q <= (seen_q == MIN_REPEATS) ? seen_q : seen_q + 4'h1;
      end
    end
  end

  // Validation test
  logic meet;                               // Candidate passes the ratio
  always_comb begin
    if (ratioSel_q) begin
      meet = onesIn(hist_q & WIN_SHORT) >= THR_SHORT;  // RL3
    end else begin
      meet = onesIn(hist_q & WIN_LONG) >= THR_LONG;  // RL3
    end
    // All-ones never validates
    meet = meet && seen_q == MIN_REPEATS && cand_q != CODE_NONE;  // RL1
  end

  // Reported code and change event
  logic [5:0] rxCode_q;                     // Reported code
  logic       rxValid_q;                    // Code currently valid
  logic       codeChg;                      // Valid code appeared or left
  assign codeChg = (meet && (!rxValid_q || rxCode_q != cand_q)) || (!meet && rxValid_q);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxCode_q  <= CODE_NONE;
      rxValid_q <= 1'b0;
    end else if (meet) begin
      rxCode_q  <= cand_q;
      rxValid_q <= 1'b1;
    end else begin
      rxCode_q  <= CODE_NONE;  // RL5
      rxValid_q <= 1'b0;
    end
  end

  // Sticky change flag; a new change beats the read clear
  logic feacChg_q;                          // Change seen, unread
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      feacChg_q <= 1'b0;
      feacIrq_q <= 1'b0;
    end else begin
      feacChg_q <= codeChg || (feacChg_q && !rdStat);  // RL4
      feacIrq_q <= feacChg_q && feacIen_q;  // RL4
    end
  end

  // Transmit codeword serialiser
  logic [3:0]  txBit_q;                     // Position within word
  logic [5:0]  txWord_q;                    // Code latched for this word
  logic [15:0] txImage;                     // Word image, bit 0 first
  // Code only changes at word boundaries to avoid torn words
  assign txImage = {1'b0, txWord_q, 1'b0, WORD_HDR};  // RL7
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txBit_q     <= 4'h0;
      txWord_q    <= TX_CODE_RST;
      txFeacBit_q <= 1'b1;
    end else if (txFeacReq) begin
      txBit_q <= txBit_q + 4'h1;
      if (txBit_q == WORD_LAST) begin
        txWord_q <= txCode_q;
      end
      if (txWord_q == CODE_NONE) begin
        txFeacBit_q <= 1'b1;  // RL6 RL25
      end else begin
        txFeacBit_q <= txImage[txBit_q];  // RL24
      end
    end
  end

  // Transmit overhead bits
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txCpBits_q  <= 3'h0;
      txAppBits_q <= 3'h7;
      txDlBits_q  <= 3'h7;
    end else begin
      if (txFrameStart) begin
        txCpBits_q <= {3{txPbit}};  // RL12
      end
      // Application bits unused here
      txAppBits_q <= 3'h7;  // RL11
      // Link not carried here; ones hold no flag so nothing to stuff
      txDlBits_q  <= 3'h7;  // RL20 RL22
    end
  end

  // Receive path parity
  logic rxPar_q;                            // Running parity, frame n+1
  logic prevPar_q;                          // Parity of frame n
  logic prevOk_q;                           // Frame n parity is known
  logic ferrSeen_q;                         // Framing error since last FEBE
  logic cbit_parity_error_count;                              // CP majority mismatch
  assign cbit_parity_error_count = rxCpValid && prevOk_q && majority3(rxCpBits) != prevPar_q;  // RL13
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxPar_q   <= 1'b0;
      prevPar_q <= 1'b0;
      prevOk_q  <= 1'b0;
    end else if (rxFrameEnd) begin
      prevPar_q <= rxPar_q ^ (rxInfoValid & rxInfoBit);  // RL13
      prevOk_q  <= 1'b1;
      rxPar_q   <= 1'b0;
    end else if (rxInfoValid) begin
      rxPar_q <= rxPar_q ^ rxInfoBit;
    end
  end

  // Outgoing FEBE, refreshed once per frame at CP time
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txFebeBits_q <= FEBE_OK;
      ferrSeen_q   <= 1'b0;
    end else if (rxCpValid) begin
      txFebeBits_q <= (cbit_parity_error_count || ferrSeen_q || ferrEvt) ? FEBE_ERR : FEBE_OK;  // RL14
      ferrSeen_q   <= 1'b0;
    end else if (ferrEvt) begin
      ferrSeen_q <= 1'b1;
    end
  end

  // Counter events
  logic [NUM_CNT-1:0] evt;                  // One pulse per error
  always_comb begin
    evt            = '0;
    evt[IDX_CBIT_PARITY_ERROR_COUNT] = cbit_parity_error_count;
    evt[IDX_EXCESS_ZEROS_COUNT]  = exzsEvt;
    evt[IDX_FEBE]  = rxFebeValid && rxFebeBits != FEBE_OK;  // RL14
    evt[IDX_FRAMING_BIT_ERROR_COUNT]  = ferrEvt;
    evt[IDX_LCV]   = lcvEvt;
    evt[IDX_PBIT_PARITY_ERROR_COUNT]  = perrEvt;
  end

  // Performance monitor state
  logic [CNT_W-1:0]   cnt_q  [NUM_CNT];     // Live counters
  logic [CNT_W-1:0]   hold_q [NUM_CNT];     // Holding registers
  logic [NUM_CNT-1:0] xfer;                 // Transfer request
  logic [NUM_CNT-1:0] rdHold;               // Holding register read
  logic [NUM_CNT-1:0] unread_q;             // Holding not yet read
  logic [NUM_CNT-1:0] xferSt_q;             // Sticky transfer status
  logic [NUM_CNT-1:0] ovr_q;                // Sticky overrun status

  // One counter slice per error type
  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    localparam logic [ADDR_W-1:0] ADR_I = ADR_CNT_BASE + ADDR_W'(i);
    assign xfer[i]   = hostWrStb && hostAddr == ADR_I;  // RL15
    assign rdHold[i] = hostRdStb && hostAddr == ADR_I;

    // Live count; event in the transfer cycle seeds the new interval
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_q[i] <= '0;
      end else if (xfer[i]) begin
        cnt_q[i] <= {{(CNT_W-1){1'b0}}, evt[i]};  // RL17
      end else if (evt[i] && cnt_q[i] != CNT_MAX) begin
        cnt_q[i] <= cnt_q[i] + 1'b1;  // RL16
      end
    end

    // Snapshot, untouched until the next transfer
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        hold_q[i] <= '0;
      end else if (xfer[i]) begin
        hold_q[i] <= cnt_q[i];  // RL17 RL26
      end
    end

    // Status flags; setting wins over the read clear
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        unread_q[i] <= 1'b0;
        xferSt_q[i] <= 1'b0;
        ovr_q[i]    <= 1'b0;
      end else begin
        unread_q[i] <= xfer[i] || (unread_q[i] && !rdHold[i]);
        xferSt_q[i] <= xfer[i] || (xferSt_q[i] && !rdXfer);  // RL18
        ovr_q[i]    <= (xfer[i] && unread_q[i]) || (ovr_q[i] && !rdOvr);  // RL19
      end
    end
  end

  // Transfer interrupt
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pmonIrq_q <= 1'b0;
    end else begin
      pmonIrq_q <= |(xferSt_q & pmEn_q);  // RL18
    end
  end

  // Read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hostRdData_q <= '0;
    end else if (hostRdStb) begin
      hostRdData_q <= '0;
      case (hostAddr)
        ADR_TX_CODE:   hostRdData_q[5:0] <= txCode_q;
        ADR_RX_CODE:   hostRdData_q[5:0] <= rxCode_q;
        ADR_FEAC_CFG:  hostRdData_q[1:0] <= {feacIen_q, ratioSel_q};
        ADR_FEAC_STAT: hostRdData_q[1:0] <= {rxValid_q, feacChg_q};
        ADR_PM_EN:     hostRdData_q[5:0] <= pmEn_q;
        ADR_PM_XFER:   hostRdData_q[5:0] <= xferSt_q;
        ADR_PM_OVR:    hostRdData_q[5:0] <= ovr_q;
        default: begin
          for (int j = 0; j < NUM_CNT; j++) begin
            if (rdHold[j]) begin
              hostRdData_q <= hold_q[j];  // RL15 RL26
            end
          end
        end
      endcase
    end
  end

  // Checks
  property p_noOnesValid;
    @(posedge mclk) disable iff (!arst_n) rxValid_q |-> rxCode_q != CODE_NONE;
  endproperty
  a_noOnesValid: assert property (p_noOnesValid) else $error("all-ones code validated"); // RL1

  property p_invalidOnes;
    @(posedge mclk) disable iff (!arst_n) !rxValid_q |-> rxCode_q == CODE_NONE;
  endproperty
  a_invalidOnes: assert property (p_invalidOnes) else $error("invalid code not ones"); // RL5

  property p_chgFlag;
    @(posedge mclk) disable iff (!arst_n) codeChg |=> feacChg_q ##1 (feacIrq_q == feacIen_q);
  endproperty
  a_chgFlag: assert property (p_chgFlag) else $error("code change not flagged"); // RL4

  property p_txHeader;
    @(posedge mclk) disable iff (!arst_n) txFeacReq && txBit_q < HDR_BITS |=> txFeacBit_q;
  endproperty
  a_txHeader: assert property (p_txHeader) else $error("header bit not one"); // RL7

  property p_txZero;
    @(posedge mclk) disable iff (!arst_n)
      txFeacReq && txWord_q != CODE_NONE && txBit_q == HDR_BITS |=> !txFeacBit_q;
  endproperty
  a_txZero: assert property (p_txZero) else $error("separator bit not zero"); // RL7

  property p_cpCopy;
    @(posedge mclk) disable iff (!arst_n) txFrameStart |=> txCpBits_q == {3{$past(txPbit)}};
  endproperty
  a_cpCopy: assert property (p_cpCopy) else $error("CP bits differ from P"); // RL12

  property p_febeOk;
    @(posedge mclk) disable iff (!arst_n)
      rxCpValid && !cbit_parity_error_count && !ferrSeen_q && !ferrEvt |=> txFebeBits_q == FEBE_OK;
  endproperty
  a_febeOk: assert property (p_febeOk) else $error("FEBE not 111 when clean"); // RL14

  property p_sat;
    @(posedge mclk) disable iff (!arst_n) cnt_q[IDX_LCV] == CNT_MAX && !xfer[IDX_LCV]
      |=> cnt_q[IDX_LCV] == CNT_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped"); // RL16

  property p_xfer;
    @(posedge mclk) disable iff (!arst_n)
      xfer[IDX_EXCESS_ZEROS_COUNT] |=> hold_q[IDX_EXCESS_ZEROS_COUNT] == $past(cnt_q[IDX_EXCESS_ZEROS_COUNT])
      && cnt_q[IDX_EXCESS_ZEROS_COUNT] == CNT_W'($past(evt[IDX_EXCESS_ZEROS_COUNT]));
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer lost count"); // RL17

  property p_ovr;
    @(posedge mclk) disable iff (!arst_n) xfer[IDX_PBIT_PARITY_ERROR_COUNT] && unread_q[IDX_PBIT_PARITY_ERROR_COUNT]
      |=> ovr_q[IDX_PBIT_PARITY_ERROR_COUNT] ##1 (rdOvr || ovr_q[IDX_PBIT_PARITY_ERROR_COUNT]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged"); // RL19

endmodule // cbo_cbit_overhead

// [common/cbo_pkg.sv]
// Shared constants for the C-bit overhead, alarm-channel code and PERFORMANCE_MONITOR block
package cbo_pkg;
  // Host port widths
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 16;
  // Counter geometry
  localparam int CNT_W   = 16;
  localparam int NUM_CNT = 6;
  // Register offsets
  localparam logic [ADDR_W-1:0] ADR_TX_CODE   = 8'h30;
  localparam logic [ADDR_W-1:0] ADR_RX_CODE   = 8'h31;
  localparam logic [ADDR_W-1:0] ADR_FEAC_CFG  = 8'h32;
  localparam logic [ADDR_W-1:0] ADR_FEAC_STAT = 8'h33;
  localparam logic [ADDR_W-1:0] ADR_CNT_BASE  = 8'h40;
  localparam logic [ADDR_W-1:0] ADR_PM_EN     = 8'h46;
  localparam logic [ADDR_W-1:0] ADR_PM_XFER   = 8'h47;
  localparam logic [ADDR_W-1:0] ADR_PM_OVR    = 8'h48;
  // Field positions
  localparam int CFG_RATIO_BIT  = 0;
  localparam int CFG_IEN_BIT    = 1;
  localparam int STAT_CHG_BIT   = 0;
  localparam int STAT_VALID_BIT = 1;
  // Counter slots
  localparam int IDX_CBIT_PARITY_ERROR_COUNT = 0;
  localparam int IDX_EXCESS_ZEROS_COUNT  = 1;
  localparam int IDX_FEBE  = 2;
  localparam int IDX_FRAMING_BIT_ERROR_COUNT  = 3;
  localparam int IDX_LCV   = 4;
  localparam int IDX_PBIT_PARITY_ERROR_COUNT  = 5;
  // Alarm-channel codeword layout
  localparam logic [5:0] CODE_NONE   = 6'h3F;
  localparam logic [7:0] WORD_HDR    = 8'hFF;
  localparam logic [3:0] WORD_LAST   = 4'hF;
  localparam logic [3:0] HDR_BITS    = 4'h8;
  // Validation figures
  localparam logic [3:0] MIN_REPEATS = 4'hA;
  localparam logic [3:0] THR_LONG    = 4'h8;
  localparam logic [3:0] THR_SHORT   = 4'h4;
  localparam logic [9:0] WIN_LONG    = 10'h3FF;
  localparam logic [9:0] WIN_SHORT   = 10'h01F;
  // Reset values and fixed patterns
  localparam logic [5:0] TX_CODE_RST = 6'h3F;
  localparam logic [2:0] FEBE_OK     = 3'h7;
  localparam logic [2:0] FEBE_ERR    = 3'h0;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
endpackage

// [verification/cbo_far_end.sv]
// Far-end terminal model that sends alarm-channel words to the receiver
`timescale 1ns/1ps
module cbo_far_end (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Word request from the bench
  input  wire logic       sendOn,
  input  wire logic [5:0] sendCode,
  // Alarm channel toward the block
  output logic            feacBit_q,
  output logic            feacValid_q,
  output logic [7:0]      words_q
);
  logic [1:0]  div_q;  // One bit every four clocks
  logic [3:0]  pos_q;  // Bit slot in the word
  logic [15:0] sh_q;   // Word being shifted out
  logic [15:0] img;    // Next word, slot 0 in bit 0
  // Ones header, zero, code LSB first, zero; idle is all ones
  assign img = sendOn ? {1'b0, sendCode, 1'b0, 8'hFF} : 16'hFFFF;
  // Serialiser; a word is taken whole so a code change never splits it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_q       <= 2'h0;
      pos_q       <= 4'h0;
      sh_q        <= 16'hFFFF;
      feacBit_q   <= 1'b1;
      feacValid_q <= 1'b0;
      words_q     <= 8'h00;
    end else begin
      div_q       <= div_q + 2'h1;
      feacValid_q <= (div_q == 2'h3);
      if (div_q == 2'h3) begin
        // Right-most bit goes first
        feacBit_q <= (pos_q == 4'h0) ? img[0] : sh_q[1];
        sh_q      <= (pos_q == 4'h0) ? img : (sh_q >> 1);
        pos_q     <= pos_q + 4'h1;
        words_q   <= words_q + {7'h00, pos_q == 4'hF};
      end else begin
        // Unqualified slots toggle, so a stale bit is never read by luck
        feacBit_q <= ~feacBit_q;
      end
    end
  end
endmodule // cbo_far_end

// [verification/tb.sv]
// Self-checking bench for the C-bit overhead, alarm code and counter block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb;
  import cbo_pkg::*;
  // Stimulus, all set at time zero
  logic              mclk = 1'b0, arst_n = 1'b0, hostWrStb = 1'b0, hostRdStb = 1'b0;
  logic [ADDR_W-1:0] hostAddr = 8'h00;
  logic [DATA_W-1:0] hostWrData = 16'h0000;
  logic              txFeacReq = 1'b0, txFrameStart = 1'b0, txPbit = 1'b0, sendOn = 1'b0;
  logic              rxInfoBit = 1'b0, rxInfoValid = 1'b0, rxFrameEnd = 1'b0;
  logic              rxCpValid = 1'b0;
  logic [2:0]        rxCpBits = 3'h0, febeIn = 3'h7;
  logic [5:0]        evt = 6'h00;       // Error events, one bit per counter slot
  logic [5:0]        sendCode = 6'h3F;  // Code the far end sends
  // Observed outputs
  logic [DATA_W-1:0] hostRdData_q;
  logic              feacIrq_q, pmonIrq_q, rxFeacBit, rxFeacValid, txFeacBit_q;
  logic [2:0]        txCpBits_q, txFebeBits_q, txAppBits_q, txDlBits_q;
  logic [7:0]        words_q;           // Words sent by the far end
  int                miscompares = 0, cmp_count = 0;
  // Block under test; events from the one-hot vector
  cbo_cbit_overhead u_cbo_cbit_overhead (.*, .rxFebeBits(febeIn),
    .rxFebeValid(evt[IDX_FEBE]), .exzsEvt(evt[IDX_EXCESS_ZEROS_COUNT]), .ferrEvt(evt[IDX_FRAMING_BIT_ERROR_COUNT]),
    .lcvEvt(evt[IDX_LCV]), .perrEvt(evt[IDX_PBIT_PARITY_ERROR_COUNT]));
  // Far-end terminal on the receive alarm channel
  cbo_far_end u_cbo_far_end (.mclk(mclk), .arst_n(arst_n), .sendOn(sendOn),
    .sendCode(sendCode), .feacBit_q(rxFeacBit), .feacValid_q(rxFeacValid), .words_q(words_q));
  // 100 MHz clock
  always #5 mclk = ~mclk;
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Host access: a write, or a read checked in the cycle after its strobe
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    hostAddr   <= a;
    hostWrData <= d;
    hostWrStb  <= w;
    hostRdStb  <= !w;
    @(posedge mclk);
    hostWrStb  <= 1'b0;
    hostRdStb  <= 1'b0;
    #1 if (!w) `CHK($sformatf("reg %h", a), d, hostRdData_q)
  endtask
  // One error event on counter slot i
  task automatic ev(input int i);
    @(posedge mclk);
    evt <= 6'h01 << i;
    @(posedge mclk);
    evt <= 6'h00;
  endtask
  // Wait for n more far-end words; a stuck far end ends the run
  task automatic wwords(input int n);
    logic [7:0] tgt;
    tgt = words_q + n[7:0];
    for (int k = 0; k < 80 * n && words_q != tgt; k++) @(posedge mclk);
    if (words_q != tgt) begin
      miscompares++;
      give_verdict();
    end
    repeat (6) @(posedge mclk);
  endtask
  // Framer takes bits lo..hi of a word, each checked the cycle after its request
  task automatic pull(input logic [15:0] w, input int lo, input int hi);
    for (int k = lo; k <= hi; k++) begin
      @(posedge mclk);
      txFeacReq <= 1'b1;
      @(posedge mclk);
      txFeacReq <= 1'b0;
      #1 `CHK("tx alarm bit", w[k], txFeacBit_q)
    end
  endtask
  // One-bit M-frame, then its CP bits; FEBE judged once it has settled
  task automatic frm(input logic b, input logic [2:0] cp, input logic [2:0] ex);
    @(posedge mclk);
    rxInfoBit   <= b;
    rxInfoValid <= 1'b1;
    rxFrameEnd  <= 1'b1;
    @(posedge mclk);
    rxInfoValid <= 1'b0;
    rxFrameEnd  <= 1'b0;
    rxCpBits    <= cp;
    rxCpValid   <= 1'b1;
    @(posedge mclk);
    rxCpValid   <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 `CHK("tx FEBE", ex, txFebeBits_q)
  endtask
  // Reset state, idle overhead bits, CP copy and an unmapped address
  task automatic t_idle();
    #1 `CHK("tx app bits", 3'h7, txAppBits_q)
    `CHK("tx DL bits", 3'h7, txDlBits_q)
    `CHK("tx alarm idle", 1'b1, txFeacBit_q)
    bus(0, ADR_RX_CODE, 16'h003F);
    bus(0, ADR_FEAC_CFG, 16'h0000);
    bus(1, 8'h7F, 16'h1234);
    bus(0, 8'h7F, 16'h0000);
    for (int p = 1; p >= 0; p--) begin
      @(posedge mclk);
      txPbit       <= p[0];
      txFrameStart <= 1'b1;
      @(posedge mclk);
      txFrameStart <= 1'b0;
      #1 `CHK("tx CP bits", {3{p[0]}}, txCpBits_q)
    end
  endtask
  // Code repeats word after word until all ones is written mid-word
  task automatic t_tx();
    logic [15:0] w;
    w = {1'b0, 6'h07, 1'b0, 8'hFF};
    bus(1, ADR_TX_CODE, 16'h0007);
    pull(16'hFFFF, 0, 15);
    pull(w, 0, 15);
    pull(w, 0, 7);
    bus(1, ADR_TX_CODE, {10'h000, CODE_NONE});
    pull(w, 8, 15);
    pull(16'hFFFF, 0, 15);
  endtask
  // Validation after ten words, loss, ignored all-ones code, both ratios
  task automatic t_rx();
    bus(1, ADR_FEAC_CFG, 16'h0002);
    bus(0, ADR_FEAC_CFG, 16'h0002);
    sendCode <= 6'h07;
    sendOn   <= 1'b1;
    wwords(1);
    wwords(10);
    bus(0, ADR_RX_CODE, 16'h003F);
    wwords(1);
    `CHK("alarm irq on valid", 1'b1, feacIrq_q)
    bus(0, ADR_RX_CODE, 16'h0007);
    bus(0, ADR_FEAC_STAT, 16'h0003);
    repeat (4) @(posedge mclk);
    `CHK("alarm irq cleared", 1'b0, feacIrq_q)
    sendCode <= CODE_NONE;
    for (int k = 0; k < 20 && feacIrq_q !== 1'b1; k++) wwords(1);
    bus(0, ADR_RX_CODE, 16'h003F);
    bus(0, ADR_FEAC_STAT, 16'h0001);
    wwords(12);
    bus(0, ADR_RX_CODE, 16'h003F);
    `CHK("no irq for all ones", 1'b0, feacIrq_q)
    bus(1, ADR_FEAC_CFG, 16'h0003);
    sendCode <= 6'h19;
    wwords(12);
    bus(0, ADR_RX_CODE, 16'h0019);
  endtask
  // Path parity of frame n against CP majority, and a framing error
  task automatic t_par();
    frm(1'b1, 3'h7, 3'h7);
    frm(1'b0, 3'h3, 3'h0);
    frm(1'b1, 3'h5, 3'h7);
    ev(IDX_FRAMING_BIT_ERROR_COUNT);
    frm(1'b0, 3'h1, 3'h0);
  endtask
  // Transfers, held counts, interrupt mask and clear, overrun
  task automatic t_performance_monitor();
    for (int i = 0; i < NUM_CNT; i++) bus(1, ADR_CNT_BASE + i[7:0], 16'h0000);
    for (int i = 0; i < NUM_CNT; i++) bus(0, ADR_CNT_BASE + i[7:0],
      16'((i == IDX_CBIT_PARITY_ERROR_COUNT || i == IDX_FRAMING_BIT_ERROR_COUNT) ? 1 : 0));
    bus(0, ADR_PM_XFER, 16'h003F);
    `CHK("performance_monitor irq masked", 1'b0, pmonIrq_q)
    bus(1, ADR_PM_EN, 16'h003F);
    ev(IDX_FEBE);
    febeIn <= 3'h2;
    for (int i = 1; i < NUM_CNT; i++) repeat (i + 1) ev(i);
    for (int i = 0; i < NUM_CNT; i++) bus(1, ADR_CNT_BASE + i[7:0], 16'h0000);
    ev(IDX_EXCESS_ZEROS_COUNT);
    `CHK("performance_monitor irq", 1'b1, pmonIrq_q)
    for (int i = 0; i < NUM_CNT; i++) bus(0, ADR_CNT_BASE + i[7:0],
      16'((i == 0) ? 0 : i + 1));
    bus(0, ADR_PM_XFER, 16'h003F);
    repeat (3) @(posedge mclk);
    `CHK("performance_monitor irq cleared", 1'b0, pmonIrq_q)
    bus(0, ADR_PM_OVR, 16'h0000);
    bus(1, ADR_CNT_BASE, 16'h0000);
    bus(1, ADR_CNT_BASE, 16'h0000);
    bus(0, ADR_PM_OVR, 16'h0001);
  endtask
  // A counter kept busy past its range must stop at the top
  task automatic t_sat();
    bus(1, ADR_CNT_BASE + 8'(IDX_LCV), 16'h0000);
    @(posedge mclk);
    evt <= 6'h01 << IDX_LCV;
    repeat (65540) @(posedge mclk);
    evt <= 6'h00;
    bus(1, ADR_CNT_BASE + 8'(IDX_LCV), 16'h0000);
    bus(0, ADR_CNT_BASE + 8'(IDX_LCV), CNT_MAX);
  endtask
  // Reset for ten cycles, then the scenarios in turn
  initial begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    t_idle();
    t_tx();
    t_rx();
    t_par();
    t_performance_monitor();
    t_sat();
    give_verdict();
  end
endmodule // tb
